/* hdl/sap_pkg.sv */
// shared constants for the servo amplifier speed port
// assumes a 200 MHz core clock; times are given in their own unit and turned into cycle counts here
package sap_pkg;
   localparam int CLK_HZ = 200_000_000;
   localparam int SERVO_ENC_TYPE = 3;
   localparam int ENC_W = 4;
   localparam int PARK_MS = 250;
   localparam int UNPARK_MS = 80;
   localparam int FAULT_HOLD_MS = 250;
   localparam int SPEED_TIMEOUT_MS = 10;
   localparam int MAX_RATE_HZ = 1500;
   localparam int WORD_BITS = 16;
   localparam int PARK_CYC = PARK_MS * (CLK_HZ / 1000);
   localparam int UNPARK_CYC = UNPARK_MS * (CLK_HZ / 1000);
   localparam int FAULT_HOLD_CYC = FAULT_HOLD_MS * (CLK_HZ / 1000);
   localparam int TIMEOUT_CYC = SPEED_TIMEOUT_MS * (CLK_HZ / 1000);
   localparam logic [15:0] RATE_MAX = 16'(MAX_RATE_HZ);
   localparam logic [15:0] RATE_RESET = 16'h0000;
   localparam logic WAVE_ACCURATE = 1'b0;
   localparam logic WAVE_LONGSTEP = 1'b1;
endpackage

/* hdl/sap_spi_if.sv */
// carrier between the spi receiver and the amplifier core
// one word pulse per sixteen bits taken
`timescale 1ns/100ps
interface sap_spi_if;
   logic wordValid;
   logic [15:0] wordData;
   modport rx (output wordValid, output wordData);
   modport core (input wordValid, input wordData);
endinterface

/* hdl/sap_spi_rx.sv */
// spi speed word receiver, mode with clock idle high, sampling on rising edge
// assumes sclk and mosi are asynchronous pins; chip select is not used by the link
`timescale 1ns/100ps
module sap_spi_rx
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic spiSclk,
   input wire logic spiMosi,
   sap_spi_if.rx spi
);
   import sap_pkg::*;

   logic [2:0] sclkSync_q;
   logic [2:0] mosiSync_q;
   logic sclkLevel_q;
   logic [15:0] shift_q;
   logic [3:0] bitCnt_q;
   logic wordValid_q;

   // three stages; a change counts when stages two and three agree
   always_ff @(posedge core_clk)
   begin
      sclkSync_q <= {sclkSync_q[1:0], spiSclk};
      mosiSync_q <= {mosiSync_q[1:0], spiMosi};
   end

   wire sclkAgree = sclkSync_q[1] == sclkSync_q[2];
   wire sclkRise = sclkAgree && sclkSync_q[2] && !sclkLevel_q;
   wire mosiBit = mosiSync_q[2];

   // msb first, word applied only after the sixteenth bit
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         sclkLevel_q <= 1'b1;
         shift_q <= 16'h0000;
         bitCnt_q <= 4'h0;
         wordValid_q <= 1'b0;
      end
      else
      begin
         wordValid_q <= 1'b0;
         if (sclkAgree)
            sclkLevel_q <= sclkSync_q[2];
         if (sclkRise)
         begin
            shift_q <= {shift_q[14:0], mosiBit};
            bitCnt_q <= bitCnt_q + 4'h1;
            wordValid_q <= bitCnt_q == 4'hF;
         end
      end
   end

   assign spi.wordValid = wordValid_q;
   assign spi.wordData = shift_q;
endmodule

/* hdl/sap_amp.sv */
// servo amplifier front end: park control, status, fault hold, speed word to stepping rate
// assumes fault and overheat causes come from on-chip monitors on core_clk; spi pins are asynchronous
`timescale 1ns/100ps
// Functional notes
// - encoder type three enters servo mode
// - serial run or stop leaves servo mode
// - enable low parks, high unparks motor
// - park takes 250 ms, unpark 80 ms
// - ready low when amplifier can run; code takes ready from run state and overheat only, so ready can be low while fault is high
// - fault high on critical error, lights led
// - fault held at least 250 ms
// - speed word sets speed, zero stops
// - no word for 10 ms stops motor
// - signed 16-bit word maps to rate
// - clock idles high, sample on rise
// - last received word kept for readback
// - stepping rate limited to 1500 Hz
// - large capacitance may lower rate limit
// - accurate waveform default, long step by command
module sap_amp
#(
   parameter int PARK_CYCLES = sap_pkg::PARK_CYC,
   parameter int UNPARK_CYCLES = sap_pkg::UNPARK_CYC,
   parameter int FAULT_CYCLES = sap_pkg::FAULT_HOLD_CYC,
   parameter int TIMEOUT_CYCLES = sap_pkg::TIMEOUT_CYC
)
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic amplifierEnableIn,
   input wire logic spiSclk,
   input wire logic spiMosi,
   input wire logic [sap_pkg::ENC_W-1:0] encoderTypeSetting,
   input wire logic encoderTypeWrite,
   input wire logic saveSettingsCmd,
   input wire logic serialRunStopCmd,
   input wire logic waveSelWrite,
   input wire logic waveSelLongStep,
   input wire logic largeCapacitance,
   input wire logic [15:0] largeCapRateLimit,
   input wire logic overheat,
   input wire logic criticalError,
   output logic servoMode,
   output logic readyOut,
   output logic faultOut,
   output logic faultLed,
   output logic motorPowered,
   output logic motorRun,
   output logic motorReverse,
   output logic [15:0] stepRate,
   output logic [15:0] lastSpeedWord,
   output logic waveLongStep
);
   import sap_pkg::*;

   // elaboration guard: a zero count would make the done compares wrap round
   if (PARK_CYCLES < 1 || UNPARK_CYCLES < 1 || FAULT_CYCLES < 1 || TIMEOUT_CYCLES < 1)
   begin
      $error("sap_amp: cycle counts must be at least one");
   end

   typedef enum {ST_PARKED, ST_UNPARKING, ST_RUNNING, ST_PARKING} sap_park_t;

   sap_spi_if spi ();

   sap_spi_rx u_rx
   (
      .core_clk(core_clk),
      .rst(rst),
      .spiSclk(spiSclk),
      .spiMosi(spiMosi),
      .spi(spi)
   );

   logic [2:0] aenSync_q;
   logic aen_q;
   sap_park_t park_q, park_d;
   logic [31:0] parkCnt_q;
   logic [31:0] faultCnt_q;
   logic [31:0] idleCnt_q;
   logic storedServo_q;
   logic servo_q;
   logic ready_q, fault_q, powered_q, run_q, rev_q, wave_q;
   logic [15:0] rate_q, word_q;
   logic [ENC_W-1:0] encType_q;

   // enable pin from the controller is asynchronous
   always_ff @(posedge core_clk)
      aenSync_q <= {aenSync_q[1:0], amplifierEnableIn};

   always_ff @(posedge core_clk)
   begin
      if (rst)
         aen_q <= 1'b0;
      else if (aenSync_q[1] == aenSync_q[2])
         aen_q <= aenSync_q[2];
   end

   // servo mode: set as soon as 3 is written, save not needed; reboot brings stored value back
   wire encIsServo = encoderTypeSetting == ENC_W'(SERVO_ENC_TYPE);
   always_ff @(posedge core_clk)
   begin
      if (saveSettingsCmd && encoderTypeWrite == 1'b0)
         encType_q <= encType_q;
      if (encoderTypeWrite)
         encType_q <= encoderTypeSetting;
      if (rst)
         servo_q <= storedServo_q; // reboot restores the saved choice
      else if (encoderTypeWrite && encIsServo)
         servo_q <= 1'b1;
      else if (serialRunStopCmd)
         servo_q <= 1'b0;
   end

   // non-volatile copy: only the save command updates it, reset leaves it alone
   always_ff @(posedge core_clk)
   begin
      if (saveSettingsCmd)
         storedServo_q <= encType_q == ENC_W'(SERVO_ENC_TYPE);
   end

   // park sequencer
   wire parkDone = parkCnt_q >= 32'(PARK_CYCLES - 1);
   wire unparkDone = parkCnt_q >= 32'(UNPARK_CYCLES - 1);
   always_comb
   begin
      park_d = park_q;
      case (park_q)
         ST_PARKED: if (aen_q && servo_q) park_d = ST_UNPARKING;
         ST_UNPARKING: if (!aen_q || !servo_q) park_d = ST_PARKING;
                       else if (unparkDone) park_d = ST_RUNNING;
         ST_RUNNING: if (!aen_q || !servo_q) park_d = ST_PARKING;
         ST_PARKING: if (parkDone) park_d = ST_PARKED;
         default: park_d = ST_PARKED;
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         park_q <= ST_PARKED;
         parkCnt_q <= 32'h0000_0000;
      end
      else
      begin
         park_q <= park_d;
         parkCnt_q <= (park_d != park_q) ? 32'h0000_0000 : parkCnt_q + 32'h0000_0001;
      end
   end

   // speed word: sign is direction, magnitude clipped at the active limit
   wire [15:0] wordMag = spi.wordData[15] ? 16'(-spi.wordData) : spi.wordData;
   wire [15:0] rateLimit = (largeCapacitance && largeCapRateLimit < RATE_MAX) ? largeCapRateLimit
                           : RATE_MAX;
   wire [15:0] rateClip = (wordMag > rateLimit) ? rateLimit : wordMag;
   wire speedTimeout = idleCnt_q >= 32'(TIMEOUT_CYCLES - 1);
   wire canRun = park_q == ST_RUNNING && !overheat && !fault_q;

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         idleCnt_q <= 32'h0000_0000;
         word_q <= 16'h0000;
         rate_q <= RATE_RESET;
         rev_q <= 1'b0;
         run_q <= 1'b0;
      end
      else
      begin
         if (spi.wordValid)
         begin
            idleCnt_q <= 32'h0000_0000;
            word_q <= spi.wordData;
            rate_q <= rateClip;
            rev_q <= spi.wordData[15];
         end
         else if (!speedTimeout)
            idleCnt_q <= idleCnt_q + 32'h0000_0001;
         else
            rate_q <= 16'h0000;
         // a stale or zero word stops stepping; a new nonzero word restarts it
         run_q <= canRun && (spi.wordValid ? rateClip != 16'h0000 : (rate_q != 16'h0000 && !speedTimeout));
      end
   end

   // fault stretched so a short glitch still shows for the full hold
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         fault_q <= 1'b0;
         faultCnt_q <= 32'h0000_0000;
      end
      else if (criticalError)
      begin
         fault_q <= 1'b1;
         faultCnt_q <= 32'h0000_0000;
      end
      else if (fault_q)
      begin
         faultCnt_q <= faultCnt_q + 32'h0000_0001;
         if (faultCnt_q >= 32'(FAULT_CYCLES - 1))
            fault_q <= 1'b0;
      end
   end

   // status and waveform; accurate shape after power-on
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         ready_q <= 1'b1;
         powered_q <= 1'b0;
         wave_q <= WAVE_ACCURATE;
      end
      else
      begin
         ready_q <= !(park_q == ST_RUNNING && !overheat);
         powered_q <= park_q != ST_PARKED;
         if (waveSelWrite)
            wave_q <= waveSelLongStep ? WAVE_LONGSTEP : WAVE_ACCURATE;
      end
   end

   assign servoMode = servo_q;
   assign readyOut = ready_q;
   assign faultOut = fault_q;
   assign faultLed = fault_q;
   assign motorPowered = powered_q;
   assign motorRun = run_q;
   assign motorReverse = rev_q;
   assign stepRate = rate_q;
   assign lastSpeedWord = word_q;
   assign waveLongStep = wave_q;

   property p_rate_limit;
      @(posedge core_clk) disable iff (rst) stepRate <= RATE_MAX;
   endproperty
   a_rate_limit: assert property (p_rate_limit) else $error("rate above limit");

   property p_fault_hold;
      @(posedge core_clk) disable iff (rst) $rose(faultOut) |-> faultOut [*8];
   endproperty
   a_fault_hold: assert property (p_fault_hold) else $error("fault dropped early");

   property p_fault_set;
      @(posedge core_clk) disable iff (rst) criticalError |=> faultOut && faultLed;
   endproperty
   a_fault_set: assert property (p_fault_set) else $error("fault not raised");

   property p_ready_parked;
      @(posedge core_clk) disable iff (rst) park_q == ST_PARKED |=> readyOut;
   endproperty
   a_ready_parked: assert property (p_ready_parked) else $error("ready low while parked");

   property p_park_on_low;
      @(posedge core_clk) disable iff (rst) park_q == ST_RUNNING && !aen_q |=> park_q == ST_PARKING;
   endproperty
   a_park_on_low: assert property (p_park_on_low) else $error("no park on enable low");

   property p_word_kept;
      @(posedge core_clk) disable iff (rst) spi.wordValid |=> lastSpeedWord == $past(spi.wordData);
   endproperty
   a_word_kept: assert property (p_word_kept) else $error("word not kept");

   property p_timeout_stop;
      @(posedge core_clk) disable iff (rst) speedTimeout && !spi.wordValid |=> !motorRun;
   endproperty
   a_timeout_stop: assert property (p_timeout_stop) else $error("run after timeout");

   property p_leave_servo;
      @(posedge core_clk) disable iff (rst) serialRunStopCmd && !encoderTypeWrite |=> !servoMode;
   endproperty
   a_leave_servo: assert property (p_leave_servo) else $error("servo kept after run cmd");

   property p_zero_stop;
      @(posedge core_clk) disable iff (rst) spi.wordValid && spi.wordData == 16'h0000 |=> !motorRun;
   endproperty
   a_zero_stop: assert property (p_zero_stop) else $error("zero word did not stop");

   c_unpark: cover property (@(posedge core_clk) disable iff (rst) park_q == ST_UNPARKING ##1 park_q == ST_RUNNING);
   c_word: cover property (@(posedge core_clk) disable iff (rst) spi.wordValid && motorRun);
   c_fault: cover property (@(posedge core_clk) disable iff (rst) $fell(faultOut));
endmodule

/* dv/sap_spi_master.sv */
// spi master model standing in for the external motion controller
// assumes core_clk is the bench clock; sclk timing is counted in its cycles
`timescale 1ns/100ps
module sap_spi_master
#(
   parameter int HALF_CYC = 200
)
(
   input wire logic core_clk,
   output logic spiSclk,
   output logic spiMosi
);
   // clock parked high between frames, it never runs free
   initial
   begin
      spiSclk = 1'b1;
      spiMosi = 1'b0;
   end
   // one word msb first; half period of 1 us keeps the link at 500 kbps
   task automatic sendWord(input logic [15:0] word);
      for (int i = 15; i >= 0; i--)
      begin
         // full high phase before every fall, so back-to-back words keep the rate limit too
         repeat (HALF_CYC) @(negedge core_clk);
         @(negedge core_clk);
         spiSclk = 1'b0;
         spiMosi = word[i];
         repeat (HALF_CYC) @(negedge core_clk);
         spiSclk = 1'b1;
      end
      // data held past the synchroniser, then shown inverted so no stale bit survives
      repeat (8) @(negedge core_clk);
      spiMosi = ~word[0];
   endtask
   // proportional term only: the word sets stepping rate, so integral or derivative action would wind up
   task automatic sendProportional(input int posErr, input int gainP);
      int cmd;
      cmd = posErr * gainP;
      if (cmd > 32'sh0000_7FFF)
         cmd = 32'sh0000_7FFF;
      else if (cmd < -32'sh0000_8000)
         cmd = -32'sh0000_8000;
      sendWord(16'(cmd));
   endtask
endmodule

/* dv/servo_amplifier_spi_speed_port_bench.sv */
// self-checking bench for the servo amplifier speed port
// assumes sap_amp with shortened park, unpark, fault and timeout counts
`timescale 1ns/100ps
module servo_amplifier_spi_speed_port_bench;
   import sap_pkg::*;
   localparam int PC = 20;
   localparam int UC = 10;
   localparam int FC = 12;
   localparam int TC = 50;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic amplifier_enable_in = 1'b0;
   logic spiSclk, spiMosi;
   logic [ENC_W-1:0] encSet = '0;
   logic encWr = 1'b0, saveCmd = 1'b0, runStop = 1'b0, waveWr = 1'b0, waveLong = 1'b0;
   logic bigCap = 1'b0, overheat = 1'b0, critErr = 1'b0;
   logic [15:0] capLimit = 16'h0320;
   logic servoMode, readyOut, faultOut, faultLed, motorPowered, motorRun, motorReverse, waveLongStep;
   logic [15:0] stepRate, lastSpeedWord;
   int failures = 0;
   int cmp_count = 0;
   // rows: word, expected rate, reverse, run
   logic [15:0] rowWord [5] = '{16'h0064, 16'hFF9C, 16'h7FFF, 16'h8000, 16'h0000};
   logic [15:0] rowRate [5] = '{16'h0064, 16'h0064, RATE_MAX, RATE_MAX, 16'h0000};
   logic rowRev [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
   logic rowRun [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};

   // 200 MHz core clock
   always #2.5 core_clk = ~core_clk;

   sap_spi_master u_spi (.core_clk(core_clk), .spiSclk(spiSclk), .spiMosi(spiMosi));

   sap_amp #(.PARK_CYCLES(PC), .UNPARK_CYCLES(UC), .FAULT_CYCLES(FC), .TIMEOUT_CYCLES(TC)) u_dut
   (
      .core_clk(core_clk), .rst(rst), .amplifierEnableIn(amplifier_enable_in), .spiSclk(spiSclk), .spiMosi(spiMosi),
      .encoderTypeSetting(encSet), .encoderTypeWrite(encWr), .saveSettingsCmd(saveCmd),
      .serialRunStopCmd(runStop), .waveSelWrite(waveWr), .waveSelLongStep(waveLong),
      .largeCapacitance(bigCap), .largeCapRateLimit(capLimit), .overheat(overheat),
      .criticalError(critErr), .servoMode(servoMode), .readyOut(readyOut), .faultOut(faultOut),
      .faultLed(faultLed), .motorPowered(motorPowered), .motorRun(motorRun),
      .motorReverse(motorReverse), .stepRate(stepRate), .lastSpeedWord(lastSpeedWord),
      .waveLongStep(waveLongStep)
   );

   task automatic results();
      $display("comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   // bounded wait for the ready level; running out ends the run
   task automatic waitReady(input logic lvl);
      int i;
      for (i = 0; i < 200 && readyOut !== lvl; i++)
         tick(1);
      if (i == 200)
      begin
         failures++;
         results();
      end
   endtask

   // one-cycle write of the encoder type, optionally saved
   task automatic encWrite(input logic [ENC_W-1:0] v, input logic save);
      encSet = v;
      encWr = 1'b1;
      tick(1);
      encWr = 1'b0;
      saveCmd = save;
      tick(1);
      saveCmd = 1'b0;
      tick(2);
   endtask

   // one-cycle waveform select strobe
   task automatic waveWrite(input logic lng);
      waveLong = lng;
      waveWr = 1'b1;
      tick(1);
      waveWr = 1'b0;
      tick(2);
   endtask

   // main sequence; inputs change on falling edges only
   initial
   begin
      tick(20);
      rst = 1'b0;
      tick(2);
      check(readyOut, 1'b1);
      check(faultOut, 1'b0);
      check(stepRate, RATE_RESET);
      check(lastSpeedWord, 16'h0000);
      check(waveLongStep, WAVE_ACCURATE);
      encWrite(4'(SERVO_ENC_TYPE), 1'b1);
      check(servoMode, 1'b1);
      runStop = 1'b1;
      tick(1);
      runStop = 1'b0;
      tick(2);
      check(servoMode, 1'b0);
      encWrite(4'h2, 1'b0);
      check(servoMode, 1'b0);
      encWrite(4'(SERVO_ENC_TYPE), 1'b0);
      check(servoMode, 1'b1);
      // unpark may not finish early
      amplifier_enable_in = 1'b1;
      tick(UC);
      check(readyOut, 1'b1);
      waitReady(1'b0);
      check(motorPowered, 1'b1);
      for (int r = 0; r < 5; r++)
      begin
         u_spi.sendWord(rowWord[r]);
         tick(4);
         check(stepRate, rowRate[r]);
         check(motorReverse, rowRev[r]);
         check(motorRun, rowRun[r]);
         check(lastSpeedWord, rowWord[r]);
      end
      // speed drops once the controller goes quiet
      u_spi.sendWord(16'h05DD);
      tick(4);
      check(stepRate, RATE_MAX);
      tick(TC + 10);
      check(stepRate, 16'h0000);
      check(motorRun, 1'b0);
      check(lastSpeedWord, 16'h05DD);
      overheat = 1'b1;
      tick(6);
      check(readyOut, 1'b1);
      check(faultOut, 1'b0);
      overheat = 1'b0;
      waitReady(1'b0);
      // single-cycle critical error must be stretched
      critErr = 1'b1;
      tick(1);
      critErr = 1'b0;
      tick(2);
      check(faultOut, 1'b1);
      check(faultLed, 1'b1);
      tick(FC - 4);
      check(faultOut, 1'b1);
      tick(10);
      check(faultOut, 1'b0);
      // park takes its full time
      amplifier_enable_in = 1'b0;
      tick(10);
      check(motorPowered, 1'b1);
      tick(PC + 10);
      check(motorPowered, 1'b0);
      check(readyOut, 1'b1);
      bigCap = 1'b1;
      amplifier_enable_in = 1'b1;
      waitReady(1'b0);
      u_spi.sendWord(16'h7FFF);
      tick(4);
      check(stepRate, capLimit);
      // a proportional-only controller output lands as an ordinary signed word
      u_spi.sendProportional(-25, 4);
      tick(4);
      check(stepRate, 16'h0064);
      check(motorReverse, 1'b1);
      waveWrite(1'b1);
      check(waveLongStep, WAVE_LONGSTEP);
      waveWrite(1'b0);
      check(waveLongStep, WAVE_ACCURATE);
      waveWrite(1'b1);
      // reboot: saved servo choice returns, run state and waveform go back to defaults
      runStop = 1'b1;
      tick(1);
      runStop = 1'b0;
      tick(2);
      check(servoMode, 1'b0);
      rst = 1'b1;
      tick(4);
      rst = 1'b0;
      tick(2);
      check(servoMode, 1'b1);
      check(readyOut, 1'b1);
      check(motorPowered, 1'b0);
      check(stepRate, RATE_RESET);
      check(lastSpeedWord, 16'h0000);
      check(waveLongStep, WAVE_ACCURATE);
      waitReady(1'b0);
      results();
   end
endmodule
